// ### design/conv_clock_divider.sv
// Converter clock tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider
#(
   parameter int CNT_W = 5
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [1:0] prescale,
   output logic tick
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] last;

   always_comb
   begin
      // 00 -> 32, 01 -> 16, 10 -> 8, 11 -> 4
      last = CNT_W'((sar_seq_pkg::DIV_MIN << (2'd3 - prescale)) - 1);
      tick = run && (cnt_r == last);
      cnt_nxt = cnt_r + 1'b1;
      if (!run || tick)
      begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// ### design/sample_averager.sv
// Accumulator that averages 1, 2, 4 or 8 samples of one channel
`timescale 1ns/1ps
`default_nettype none
module sample_averager
#(
   parameter int DATA_W = 12
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic add,
   input wire logic [DATA_W-1:0] sample,
   input wire logic [1:0] avg_sel,
   output logic [DATA_W-1:0] average
);
   logic [DATA_W+2:0] sum_r;
   logic [DATA_W+2:0] sum_nxt;
   logic [DATA_W+2:0] total;

   always_comb
   begin
      // Includes the sample being added, so the average is ready on the last add
      total = sum_r + {3'b000, sample};
      average = DATA_W'(total >> avg_sel);
      sum_nxt = sum_r;
      if (clear)
      begin
         sum_nxt = '0;
      end
      else if (add)
      begin
         sum_nxt = total;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sum_r <= '0;
      end
      else
      begin
         sum_r <= sum_nxt;
      end
   end
endmodule
`default_nettype wire

// ### design/sar_adc_sequencer.sv
// Sequencer, register file and result store of the four-channel converter
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pwm_trigger,
   input wire logic [11:0] converter_input,
   output logic analog_power_down,
   output logic conv_clock_tick,
   output logic sample_latch,
   output logic [1:0] active_channel,
   output logic [1:0] mux_select,
   output logic autozero_ref_select,
   output logic autozero_disable,
   output logic comparator_chop_disable,
   output logic busy,
   output logic conv_irq
);
   localparam int RW = sar_seq_pkg::RESULT_W;
   localparam int NC = sar_seq_pkg::NUM_CHAN;

   // Register state
   logic [7:0] cfg1_r;
   logic [7:0] cfg1_nxt;
   logic [7:0] chsel_r;
   logic [7:0] chsel_nxt;
   logic [3:0] chan_en_r;
   logic [3:0] chan_en_nxt;
   logic chop_r;
   logic chop_nxt;
   logic azdis_r;
   logic azdis_nxt;
   logic done_flag_r;
   logic done_flag_nxt;
   logic fault_r;
   logic fault_nxt;
   logic soft_start_r;
   logic soft_start_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // Sequencer state
   sar_seq_pkg::seq_state_t state_r;
   sar_seq_pkg::seq_state_t state_nxt;
   logic [1:0] chan_r;
   logic [1:0] chan_nxt;
   logic [3:0] cyc_r;
   logic [3:0] cyc_nxt;
   logic [2:0] samp_r;
   logic [2:0] samp_nxt;
   logic [RW-1:0] result_r [NC];
   logic [RW-1:0] result_nxt [NC];

   // Combinational helpers
   logic conv_enable;
   logic irq_enable;
   logic result_format;
   logic [1:0] average_select;
   logic [1:0] prescale;
   logic cfg3_wr;
   logic start_evt;
   logic tick;
   logic conv_end;
   logic acc_clear;
   logic acc_add;
   logic [RW-1:0] average;
   logic [2:0] first_chan;
   logic [2:0] later_chan;
   logic [2:0] last_samp;
   logic [3:0] chen_eff;
   logic div_run;

   assign conv_enable = cfg1_r[sar_seq_pkg::CFG1_EN];
   assign irq_enable = cfg1_r[sar_seq_pkg::CFG1_IEN];
   assign result_format = cfg1_r[sar_seq_pkg::CFG1_FMT];
   assign average_select = cfg1_r[sar_seq_pkg::CFG1_AVG +: 2];
   assign prescale = cfg1_r[sar_seq_pkg::CFG1_PRE +: 2];
   assign cfg3_wr = reg_wr && (reg_addr == sar_seq_pkg::ADDR_CFG3);
   // Software start or trigger pulse; both count only with the core powered
   assign start_evt = conv_enable
      && ((cfg3_wr && reg_wdata[sar_seq_pkg::CFG3_START_WR]) || pwm_trigger);
   // A start write carries its own channel enables, so the new set picks the first channel
   assign chen_eff = cfg3_wr ? reg_wdata[sar_seq_pkg::CFG3_EN_LO +: 4] : chan_en_r;
   // Restart realigns the converter clock so the fresh conversion gets full periods
   assign div_run = (state_r == sar_seq_pkg::SEQ_CONV) && !start_evt;

   // First enabled channel at or after the given index, 4 when none is left
   function automatic logic [2:0] next_enabled(input logic [3:0] en, input logic [2:0] from);
      logic [2:0] found;
      found = 3'd4;
      for (int i = NC - 1; i >= 0; i--)
      begin
         // Channel A's enable is the top bit, D's the bottom
         if (en[NC - 1 - i] && (3'(i) >= from))
         begin
            found = 3'(i);
         end
      end
      return found;
   endfunction

   // Pack a 12-bit result into the high or low byte in the chosen justification
   function automatic logic [7:0] pack_byte(input logic [RW-1:0] res, input logic fmt,
                                            input logic high);
      logic [7:0] b;
      if (fmt)
      begin
         b = high ? res[11:4] : {res[3:0], 4'h0};
      end
      else
      begin
         b = high ? {4'h0, res[11:8]} : res[7:0];
      end
      return b;
   endfunction

   conv_clock_divider u_divider
   (
      .clk(clk),
      .rst(rst),
      .run(div_run),
      .prescale(prescale),
      .tick(tick)
   );

   sample_averager #(.DATA_W(RW)) u_averager
   (
      .clk(clk),
      .rst(rst),
      .clear(acc_clear),
      .add(acc_add),
      .sample(converter_input),
      .avg_sel(average_select),
      .average(average)
   );

   always_comb
   begin
      first_chan = next_enabled(chen_eff, 3'd0);
      later_chan = next_enabled(chan_en_r, 3'(chan_r) + 3'd1);
      last_samp = 3'((4'd1 << average_select) - 4'd1);
      conv_end = (state_r == sar_seq_pkg::SEQ_CONV) && tick
         && (cyc_r == 4'(sar_seq_pkg::CONV_CYCLES - 1));
      acc_add = conv_end && !start_evt && conv_enable;
      acc_clear = start_evt || (conv_end && (samp_r == last_samp));

      cfg1_nxt = cfg1_r;
      chsel_nxt = chsel_r;
      chan_en_nxt = chan_en_r;
      chop_nxt = chop_r;
      azdis_nxt = azdis_r;
      done_flag_nxt = done_flag_r;
      fault_nxt = fault_r;
      soft_start_nxt = soft_start_r;
      state_nxt = state_r;
      chan_nxt = chan_r;
      cyc_nxt = cyc_r;
      samp_nxt = samp_r;
      for (int i = 0; i < NC; i++)
      begin
         result_nxt[i] = result_r[i];
      end

      // Software writes first so that hardware sets below win a same-cycle clear
      if (reg_wr)
      begin
         unique case (reg_addr)
            sar_seq_pkg::ADDR_CFG1: cfg1_nxt = reg_wdata;
            sar_seq_pkg::ADDR_CHSEL: chsel_nxt = reg_wdata;
            sar_seq_pkg::ADDR_CFG3:
            begin
               chan_en_nxt = reg_wdata[sar_seq_pkg::CFG3_EN_LO +: 4];
               chop_nxt = reg_wdata[sar_seq_pkg::CFG3_CHOP_WR];
               azdis_nxt = reg_wdata[sar_seq_pkg::CFG3_AZDIS_WR];
               if (!reg_wdata[sar_seq_pkg::CFG3_DONE_WR])
               begin
                  done_flag_nxt = 1'b0;
                  fault_nxt = 1'b0;
               end
               if (reg_wdata[sar_seq_pkg::CFG3_START_WR])
               begin
                  soft_start_nxt = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
      end

      if (!conv_enable)
      begin
         // Power-down stops any sequence and drops a pending start
         state_nxt = sar_seq_pkg::SEQ_IDLE;
         soft_start_nxt = 1'b0;
         cyc_nxt = '0;
         samp_nxt = '0;
      end
      else if (start_evt)
      begin
         if (state_r == sar_seq_pkg::SEQ_CONV)
         begin
            fault_nxt = 1'b1;
         end
         cyc_nxt = '0;
         samp_nxt = '0;
         if (first_chan[2])
         begin
            // No channel enabled: the empty sequence completes at once
            state_nxt = sar_seq_pkg::SEQ_IDLE;
            done_flag_nxt = 1'b1;
            soft_start_nxt = 1'b0;
         end
         else
         begin
            state_nxt = sar_seq_pkg::SEQ_CONV;
            chan_nxt = first_chan[1:0];
         end
      end
      else if ((state_r == sar_seq_pkg::SEQ_CONV) && tick)
      begin
         cyc_nxt = cyc_r + 4'd1;
         if (conv_end)
         begin
            samp_nxt = samp_r + 3'd1;
            if (samp_r == last_samp)
            begin
               // Whole average of this channel before moving on
               result_nxt[chan_r] = average;
               samp_nxt = '0;
               if (later_chan[2])
               begin
                  state_nxt = sar_seq_pkg::SEQ_IDLE;
                  done_flag_nxt = 1'b1;
                  soft_start_nxt = 1'b0;
               end
               else
               begin
                  chan_nxt = later_chan[1:0];
               end
            end
         end
      end

      rdata_nxt = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            sar_seq_pkg::ADDR_CFG1: rdata_nxt = cfg1_r;
            sar_seq_pkg::ADDR_CHSEL: rdata_nxt = chsel_r;
            sar_seq_pkg::ADDR_CFG3: rdata_nxt = {chan_en_r, fault_r, done_flag_r,
                                                 state_r == sar_seq_pkg::SEQ_CONV, 1'b0};
            sar_seq_pkg::ADDR_A_LOW: rdata_nxt = pack_byte(result_r[0], result_format, 1'b0);
            sar_seq_pkg::ADDR_A_HIGH: rdata_nxt = pack_byte(result_r[0], result_format, 1'b1);
            sar_seq_pkg::ADDR_B_LOW: rdata_nxt = pack_byte(result_r[1], result_format, 1'b0);
            sar_seq_pkg::ADDR_B_HIGH: rdata_nxt = pack_byte(result_r[1], result_format, 1'b1);
            sar_seq_pkg::ADDR_C_LOW: rdata_nxt = pack_byte(result_r[2], result_format, 1'b0);
            sar_seq_pkg::ADDR_C_HIGH: rdata_nxt = pack_byte(result_r[2], result_format, 1'b1);
            sar_seq_pkg::ADDR_D_LOW: rdata_nxt = pack_byte(result_r[3], result_format, 1'b0);
            sar_seq_pkg::ADDR_D_HIGH: rdata_nxt = pack_byte(result_r[3], result_format, 1'b1);
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg1_r <= sar_seq_pkg::CFG1_RESET;
         chsel_r <= sar_seq_pkg::CHSEL_RESET;
         chan_en_r <= sar_seq_pkg::CHEN_RESET;
         chop_r <= 1'b0;
         azdis_r <= 1'b0;
         done_flag_r <= 1'b0;
         fault_r <= 1'b0;
         soft_start_r <= 1'b0;
         rdata_r <= 8'h00;
         state_r <= sar_seq_pkg::SEQ_IDLE;
         chan_r <= 2'd0;
         cyc_r <= 4'd0;
         samp_r <= 3'd0;
         for (int i = 0; i < NC; i++)
         begin
            result_r[i] <= '0;
         end
      end
      else
      begin
         cfg1_r <= cfg1_nxt;
         chsel_r <= chsel_nxt;
         chan_en_r <= chan_en_nxt;
         chop_r <= chop_nxt;
         azdis_r <= azdis_nxt;
         done_flag_r <= done_flag_nxt;
         fault_r <= fault_nxt;
         soft_start_r <= soft_start_nxt;
         rdata_r <= rdata_nxt;
         state_r <= state_nxt;
         chan_r <= chan_nxt;
         cyc_r <= cyc_nxt;
         samp_r <= samp_nxt;
         for (int i = 0; i < NC; i++)
         begin
            result_r[i] <= result_nxt[i];
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign analog_power_down = !conv_enable;
   assign conv_clock_tick = tick;
   assign sample_latch = acc_add;
   assign active_channel = chan_r;
   // Channel A field sits in the top bits, D in the bottom
   assign mux_select = chsel_r[6 - 2 * chan_r +: 2];
   assign autozero_ref_select = cfg1_r[sar_seq_pkg::CFG1_AZ];
   assign autozero_disable = azdis_r;
   // Chop only steers the analogue comparator; conversion length stays fixed
   assign comparator_chop_disable = chop_r;
   assign busy = (state_r == sar_seq_pkg::SEQ_CONV);
   // Level request, held until software clears the completion flag
   assign conv_irq = done_flag_r && irq_enable;
endmodule
`default_nettype wire

// ### design/sar_seq_pkg.sv
// Constants shared by the converter sequencer and its helpers
// Functional notes
// - Four channels A to D, each with its own 12-bit result register pair.
// - A sequence starts on a software start bit write or a PWM trigger pulse.
// - Each start converts every enabled channel in order A to D, once per averaged sample.
// - Each single conversion lasts 16 converter clocks, chop setting regardless.
// - With the enable bit low the core is powered down and never converts.
// - Prescaler 00/01/10/11 divides system clock by 32/16/8/4; reset value 11.
// - Sequence end raises the interrupt only while interrupt enable is set.
// - Busy status reads 1 during a sequence and 0 when idle.
// - A start during a running sequence aborts it and starts a fresh one.
// - Format 1: high byte bits 11..4, low byte bits 3..0 then zero nibble.
// - Format 0: high byte zero nibble and bits 11..8, low byte bits 7..0.
// - Averaging field 00/01/10/11 selects 1/2/4/8 samples; reset value 00.
// - With averaging, one channel's average completes before the next channel.
// - Auto-zero select 0 uses converter input, 1 uses fixed 1 V reference.
// - Each channel enable bit includes its channel in the sequence.
// - The software start bit clears itself when the sequence finishes.
// - Completion flag set on sequence end; software clears it by writing 0.
// - Fault set on retrigger before completion; cleared with the completion flag.
package sar_seq_pkg;
   localparam logic [7:0] ADDR_CFG1 = 8'hB9;
   localparam logic [7:0] ADDR_CHSEL = 8'hA9;
   localparam logic [7:0] ADDR_CFG3 = 8'hCE;
   localparam logic [7:0] ADDR_A_LOW = 8'hBA;
   localparam logic [7:0] ADDR_A_HIGH = 8'hBB;
   localparam logic [7:0] ADDR_B_LOW = 8'hBC;
   localparam logic [7:0] ADDR_B_HIGH = 8'hBD;
   localparam logic [7:0] ADDR_C_LOW = 8'hBE;
   localparam logic [7:0] ADDR_C_HIGH = 8'hBF;
   localparam logic [7:0] ADDR_D_LOW = 8'hAA;
   localparam logic [7:0] ADDR_D_HIGH = 8'hAB;

   // Config one fields
   localparam int CFG1_AZ = 7;
   localparam int CFG1_EN = 6;
   localparam int CFG1_IEN = 5;
   localparam int CFG1_FMT = 4;
   localparam int CFG1_AVG = 2;
   localparam int CFG1_PRE = 0;
   localparam logic [7:0] CFG1_RESET = 8'h03;
   localparam logic [7:0] CHSEL_RESET = 8'h00;

   // Config three fields; flag and start sit at different write and read positions
   localparam int CFG3_EN_LO = 4;
   localparam int CFG3_FAULT_RD = 3;
   localparam int CFG3_DONE_RD = 2;
   localparam int CFG3_BUSY_RD = 1;
   localparam int CFG3_CHOP_WR = 3;
   localparam int CFG3_AZDIS_WR = 2;
   localparam int CFG3_DONE_WR = 1;
   localparam int CFG3_START_WR = 0;
   localparam logic [3:0] CHEN_RESET = 4'h0;

   localparam int RESULT_W = 12;
   localparam int NUM_CHAN = 4;
   localparam int CONV_CYCLES = 16;
   localparam int SETTLE_TIME_NS = 2000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_MIN = 4;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_CONV = 2'b10
   } seq_state_t;
endpackage

// ### tb/sar_adc_sequencer_monitor.sv
// Port-level assertion checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic pwm_trigger,
   input wire logic analog_power_down,
   input wire logic conv_clock_tick,
   input wire logic sample_latch,
   input wire logic [1:0] active_channel,
   input wire logic busy,
   input wire logic conv_irq
);
   logic [3:0] chen_r, chen_nxt, chen_eff, tick_r, tick_nxt;
   logic en_r, en_nxt, ien_r, ien_nxt, cfg3_w, start_w;
   logic [1:0] first_ch;

   // Mirrors only the control bits; a start write also carries the channel enables
   always_comb
   begin
      cfg3_w = reg_wr && reg_addr == sar_seq_pkg::ADDR_CFG3;
      start_w = pwm_trigger || (cfg3_w && reg_wdata[sar_seq_pkg::CFG3_START_WR]);
      chen_eff = cfg3_w ? reg_wdata[7:4] : chen_r;
      chen_nxt = chen_eff;
      en_nxt = en_r;
      ien_nxt = ien_r;
      if (reg_wr && reg_addr == sar_seq_pkg::ADDR_CFG1)
      begin
         en_nxt = reg_wdata[sar_seq_pkg::CFG1_EN];
         ien_nxt = reg_wdata[sar_seq_pkg::CFG1_IEN];
      end
      first_ch = chen_eff[3] ? 2'h0 : chen_eff[2] ? 2'h1 : chen_eff[1] ? 2'h2 : 2'h3;
      // A restart or idle period voids a partly counted conversion
      tick_nxt = (start_w || !busy || sample_latch) ? 4'h0 : tick_r + {3'h0, conv_clock_tick};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         chen_r <= 4'h0;
         en_r <= 1'b0;
         ien_r <= 1'b0;
         tick_r <= 4'h0;
      end
      else
      begin
         chen_r <= chen_nxt;
         en_r <= en_nxt;
         ien_r <= ien_nxt;
         tick_r <= tick_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_start_busy: assert property (start_w && en_r && chen_eff != 4'h0 |=> busy)
      else $error("busy did not follow a start");
   chk_first_chan: assert property (start_w && en_r && chen_eff != 4'h0 |=>
      active_channel == $past(first_ch)) else $error("sequence began on wrong channel");
   chk_conv_length: assert property (sample_latch |-> tick_r == 4'hF)
      else $error("conversion not sixteen ticks long");
   chk_latch_on_tick: assert property (sample_latch |-> conv_clock_tick && busy)
      else $error("sample taken off a converter tick");
   chk_tick_spacing: assert property (conv_clock_tick |=> !conv_clock_tick [*3])
      else $error("converter ticks too close");
   chk_power_down: assert property (analog_power_down == !en_r)
      else $error("power down does not follow enable");
   chk_off_idle: assert property (!en_r |=> !busy)
      else $error("sequence runs while powered down");
   chk_idle_no_tick: assert property (!busy |-> !conv_clock_tick)
      else $error("tick while idle");
   chk_irq_at_end: assert property ($fell(busy) && en_r && ien_r |-> conv_irq)
      else $error("no interrupt at sequence end");
   chk_irq_gated: assert property (conv_irq |-> ien_r)
      else $error("interrupt while disabled");
endmodule

bind sar_adc_sequencer sar_adc_monitor i_mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
   .pwm_trigger, .analog_power_down, .conv_clock_tick, .sample_latch, .active_channel,
   .busy, .conv_irq);
`default_nettype wire

// ### tb/sar_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_test;
   logic clk, rst, reg_wr, reg_rd, pwm_trigger, analog_power_down, conv_clock_tick;
   logic sample_latch, autozero_ref_select, autozero_disable, comparator_chop_disable;
   logic busy, conv_irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [11:0] converter_input;
   logic [1:0] active_channel, mux_select;
   int fail_count = 0;
   int cmp_count = 0;
   localparam logic [7:0] LO_TAB [4] = '{sar_seq_pkg::ADDR_A_LOW, sar_seq_pkg::ADDR_B_LOW,
      sar_seq_pkg::ADDR_C_LOW, sar_seq_pkg::ADDR_D_LOW};

   sar_adc_sequencer i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pwm_trigger, .converter_input, .analog_power_down, .conv_clock_tick, .sample_latch,
      .active_channel, .mux_select, .autozero_ref_select, .autozero_disable,
      .comparator_chop_disable, .busy, .conv_irq);

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Analogue stand-in: each taken sample steps the input, so averages are predictable
   always @(posedge clk)
      if (sample_latch === 1'b1)
         converter_input <= converter_input + 12'h010;

   task automatic wrap_up();
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic cmpi(input int got, input int exp, input string m);
      cmp_count++;
      if (got != exp)
      begin
         fail_count++;
         $display("Error %0t: %s took %0d expected %0d", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic chkrd(input logic [7:0] a, input logic [7:0] exp, input string m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      cmp(reg_rdata, exp, m);
   endtask

   task automatic cnt_busy(input int exp, input string m);
      int k;
      k = 0;
      @(negedge clk);
      while (busy === 1'b1 && k < 5000)
      begin
         k++;
         @(negedge clk);
      end
      cmpi(k, exp, m);
   endtask

   task automatic run(input logic [7:0] c3, input int exp, input string m);
      wr(sar_seq_pkg::ADDR_CFG3, c3);
      cnt_busy(exp, m);
   endtask

   // Right-justified pair, the format left in place by most scenarios
   task automatic chkres(input int ch, input logic [11:0] v);
      chkrd(LO_TAB[ch] + 8'h01, {4'h0, v[11:8]}, "result high");
      chkrd(LO_TAB[ch], v[7:0], "result low");
   endtask

   task automatic t_reset();
      chkrd(sar_seq_pkg::ADDR_CFG1, sar_seq_pkg::CFG1_RESET, "cfg1 reset");
      chkrd(sar_seq_pkg::ADDR_CHSEL, 8'h00, "chsel reset");
      chkrd(sar_seq_pkg::ADDR_CFG3, 8'h00, "cfg3 reset");
      chkrd(8'hC0, 8'h00, "unmapped read");
      cmp({7'h0, analog_power_down}, 8'h01, "power down");
      run(8'h81, 0, "start while off");
   endtask

   task automatic t_single();
      // Prescale 10 sets the converter clock to 2.5 MHz, used by every scenario after this except the prescale sweep
      wr(sar_seq_pkg::ADDR_CFG1, 8'h62);
      // Bias settling is the software's wait, not the block's
      repeat (sar_seq_pkg::SETTLE_CYCLES) @(posedge clk);
      converter_input <= 12'hA5C;
      run(8'h81, 128, "single A");
      cmp({7'h0, conv_irq}, 8'h01, "irq at end");
      chkrd(sar_seq_pkg::ADDR_CFG3, 8'h84, "status done");
      chkres(0, 12'hA5C);
      wr(sar_seq_pkg::ADDR_CFG1, 8'h72);
      wr(sar_seq_pkg::ADDR_A_LOW, 8'hFF);
      chkrd(sar_seq_pkg::ADDR_A_HIGH, 8'hA5, "left high");
      chkrd(sar_seq_pkg::ADDR_A_LOW, 8'hC0, "left low");
      wr(sar_seq_pkg::ADDR_CFG1, 8'h62);
      wr(sar_seq_pkg::ADDR_CFG3, 8'h80);
      @(negedge clk);
      cmp({7'h0, conv_irq}, 8'h00, "irq cleared");
   endtask

   task automatic t_prescale();
      for (int p = 0; p < 3; p++)
      begin
         wr(sar_seq_pkg::ADDR_CFG1, 8'h40 | 8'(p));
         run(8'h41, 16 * (32 >> p), "prescale");
      end
   endtask

   task automatic t_avg();
      for (int a = 0; a < 4; a++)
      begin
         converter_input <= 12'h200;
         wr(sar_seq_pkg::ADDR_CFG1, 8'h42 | 8'(a << 2));
         run(8'h11, 128 << a, "average length");
         chkres(3, 12'h200 + 12'(8 * ((1 << a) - 1)));
      end
      converter_input <= 12'h300;
      wr(sar_seq_pkg::ADDR_CFG1, 8'h46);
      run(8'hB1, 768, "three channels");
      chkres(0, 12'h308);
      chkres(2, 12'h328);
      chkres(3, 12'h348);
   endtask

   task automatic t_abort();
      wr(sar_seq_pkg::ADDR_CFG1, 8'h42);
      wr(sar_seq_pkg::ADDR_CFG3, 8'h81);
      repeat (20) @(posedge clk);
      pwm_trigger <= 1'b1;
      @(posedge clk);
      pwm_trigger <= 1'b0;
      cnt_busy(128, "restart length");
      cmp({7'h0, conv_irq}, 8'h00, "irq masked");
      chkrd(sar_seq_pkg::ADDR_CFG3, 8'h8C, "fault set");
      wr(sar_seq_pkg::ADDR_CFG3, 8'h80);
      chkrd(sar_seq_pkg::ADDR_CFG3, 8'h80, "fault cleared");
      wr(sar_seq_pkg::ADDR_CFG3, 8'h81);
      repeat (10) @(posedge clk);
      wr(sar_seq_pkg::ADDR_CFG1, 8'h02);
      // The sequencer sees the cleared enable one cycle after the write lands
      repeat (2) @(negedge clk);
      cmp({7'h0, busy}, 8'h00, "disable aborts");
      chkrd(sar_seq_pkg::ADDR_CFG3, 8'h80, "no done");
   endtask

   // Analogue steering pins, with chop disabled during a run on channel B
   task automatic t_pins();
      wr(sar_seq_pkg::ADDR_CHSEL, 8'h6C);
      wr(sar_seq_pkg::ADDR_CFG1, 8'hC2);
      repeat (sar_seq_pkg::SETTLE_CYCLES) @(posedge clk);
      run(8'h4D, 128, "chop length");
      cmp({6'h0, active_channel}, 8'h01, "active channel");
      cmp({6'h0, mux_select}, 8'h02, "mux select");
      cmp({7'h0, autozero_ref_select}, 8'h01, "autozero ref");
      cmp({6'h0, comparator_chop_disable, autozero_disable}, 8'h03, "chop pins");
      chkrd(sar_seq_pkg::ADDR_CHSEL, 8'h6C, "chsel readback");
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      pwm_trigger = 1'b0;
      converter_input = 12'h000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_single();
      t_prescale();
      t_avg();
      t_abort();
      t_pins();
      wrap_up();
   end
endmodule
`default_nettype wire
